//--- logic/i2m_master.sv
`timescale 1ns/1ps
module i2m_master (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [i2m_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [i2m_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic cpu_sleep,
  output logic cpu_wake
);

  i2m_pkg::i2m_regs_t r_reg;
  i2m_pkg::i2m_regs_t r_next;

  logic tick;
  logic tmo;
  logic set_pif;
  logic set_bcl;
  logic set_write_collision_flag;
  logic busy;
  logic whit;
  logic rhit;
  logic drv_bit;
  logic [7:0] widx;
  logic [7:0] ridx;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic [7:0] shifted;

  always_comb
  begin
    r_next = r_reg;
    set_pif = 1'b0;
    set_bcl = 1'b0;
    set_write_collision_flag = 1'b0;
    whit = 1'b0;
    rhit = 1'b0;
    rbyte = 8'h00;
    drv_bit = 1'b0;
    widx = r_reg.aw_addr[9:2];
    ridx = s_axi_araddr[9:2];
    wbyte = r_reg.w_data;
    shifted = {r_reg.shreg[6:0], r_reg.sda_s};
    busy = (r_reg.st != i2m_pkg::ST_IDLE) | r_reg.tx_req | (r_reg.con2[4:0] != 5'h00);

    // Pin synchronisers and edge history
    r_next.sda_m = sda_i;
    r_next.sda_s = r_reg.sda_m;
    r_next.sda_d = r_reg.sda_s;
    r_next.scl_m = scl_i;
    r_next.scl_s = r_reg.scl_m;
    r_next.scl_d = r_reg.scl_s;

    // Four phases per instruction cycle; count on the second and fourth
    r_next.phase = r_reg.phase + 2'h1;
    tick = r_reg.phase[0];
    tmo = tick & r_reg.brg_run & (r_reg.baud_rate_generator == '0);
    if (tick && r_reg.brg_run && (r_reg.baud_rate_generator != '0))
    begin
      r_next.baud_rate_generator = r_reg.baud_rate_generator - 7'h01;
    end

    // Bus condition detection, works regardless of sleep
    if (r_reg.scl_s && r_reg.scl_d && r_reg.sda_d && !r_reg.sda_s)
    begin
      r_next.start_seen = 1'b1;
      r_next.stop_seen = 1'b0;
    end
    if (r_reg.scl_s && r_reg.scl_d && !r_reg.sda_d && r_reg.sda_s)
    begin
      r_next.stop_seen = 1'b1;
      r_next.start_seen = 1'b0;
      if (r_reg.start_seen && r_reg.peripheral_interrupt_enables_1[i2m_pkg::PERIPHERAL_INTERRUPT_FLAGS_1_PIF])
      begin
        set_pif = 1'b1;
      end
    end

    // Register write, once address and data are both held
    if (r_reg.aw_held && r_reg.w_held && !r_reg.bvalid)
    begin
      whit = (r_reg.aw_addr[11:10] == 2'h0);
      if (whit)
      begin
        case (widx)
          i2m_pkg::IDX_PERIPHERAL_INTERRUPT_FLAGS_1: if (r_reg.w_lane0) r_next.peripheral_interrupt_flags_1 = wbyte;
          i2m_pkg::IDX_PERIPHERAL_INTERRUPT_FLAGS_2: if (r_reg.w_lane0) r_next.bcl = wbyte[i2m_pkg::PERIPHERAL_INTERRUPT_FLAGS_2_BCL];
          i2m_pkg::IDX_PERIPHERAL_INTERRUPT_ENABLES_1: if (r_reg.w_lane0) r_next.peripheral_interrupt_enables_1 = wbyte;
          i2m_pkg::IDX_PERIPHERAL_INTERRUPT_ENABLES_2: if (r_reg.w_lane0) r_next.bcle = wbyte[i2m_pkg::PERIPHERAL_INTERRUPT_FLAGS_2_BCL];
          i2m_pkg::IDX_RELOAD: if (r_reg.w_lane0) r_next.reload = wbyte;
          i2m_pkg::IDX_STAT:
          begin
            if (r_reg.w_lane0)
            begin
              r_next.smp = wbyte[i2m_pkg::STAT_SMP];
              r_next.cke = wbyte[i2m_pkg::STAT_CKE];
            end
          end
          i2m_pkg::IDX_CON:
          begin
            if (r_reg.w_lane0)
            begin
              r_next.write_collision_flag = wbyte[i2m_pkg::CON_WRITE_COLLISION_FLAG];
              r_next.ov = wbyte[i2m_pkg::CON_OV];
              r_next.en = wbyte[i2m_pkg::CON_EN];
              r_next.clock_release_bit = wbyte[i2m_pkg::CON_CKP];
              r_next.mode = wbyte[3:0];
            end
          end
          i2m_pkg::IDX_CON2:
          begin
            if (r_reg.w_lane0)
            begin
              r_next.con2[i2m_pkg::CON2_GENERAL_CALL_ENABLE] = wbyte[i2m_pkg::CON2_GENERAL_CALL_ENABLE];
              r_next.con2[i2m_pkg::CON2_ACK_DATA_BIT] = wbyte[i2m_pkg::CON2_ACK_DATA_BIT];
              // Command bits only take while nothing is pending
              if (!busy && r_reg.en)
              begin
                r_next.con2[4:0] = wbyte[4:0];
              end
            end
          end
          i2m_pkg::IDX_BUF:
          begin
            if (r_reg.w_lane0)
            begin
              if (busy || !r_reg.en)
              begin
                set_write_collision_flag = 1'b1;
              end
              else
              begin
                r_next.buf_data = wbyte;
                r_next.shreg = wbyte;
                r_next.bf = 1'b1;
                r_next.tx_req = 1'b1;
              end
            end
          end
          default: whit = 1'b0;
        endcase
      end
      r_next.bvalid = 1'b1;
      r_next.bresp = whit ? i2m_pkg::RESP_OKAY : i2m_pkg::RESP_SLVERR;
      r_next.aw_held = 1'b0;
      r_next.w_held = 1'b0;
    end
    if (s_axi_awvalid && !r_reg.aw_held)
    begin
      r_next.aw_held = 1'b1;
      r_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r_reg.w_held)
    begin
      r_next.w_held = 1'b1;
      r_next.w_data = s_axi_wdata[7:0];
      r_next.w_lane0 = s_axi_wstrb[0];
    end
    if (r_reg.bvalid && s_axi_bready)
    begin
      r_next.bvalid = 1'b0;
    end

    // Register read; reading the buffer empties it
    if (s_axi_rvalid && s_axi_rready)
    begin
      r_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !r_reg.rvalid)
    begin
      rhit = (s_axi_araddr[11:10] == 2'h0);
      case (ridx)
        i2m_pkg::IDX_PERIPHERAL_INTERRUPT_FLAGS_1: rbyte = r_reg.peripheral_interrupt_flags_1;
        i2m_pkg::IDX_PERIPHERAL_INTERRUPT_FLAGS_2: rbyte = {4'h0, r_reg.bcl, 3'h0};
        i2m_pkg::IDX_PERIPHERAL_INTERRUPT_ENABLES_1: rbyte = r_reg.peripheral_interrupt_enables_1;
        i2m_pkg::IDX_PERIPHERAL_INTERRUPT_ENABLES_2: rbyte = {4'h0, r_reg.bcle, 3'h0};
        i2m_pkg::IDX_BUF:
        begin
          rbyte = r_reg.buf_data;
          if (rhit)
          begin
            r_next.bf = 1'b0;
          end
        end
        i2m_pkg::IDX_CON: rbyte = {r_reg.write_collision_flag, r_reg.ov, r_reg.en, r_reg.clock_release_bit, r_reg.mode};
        i2m_pkg::IDX_CON2: rbyte = r_reg.con2;
        i2m_pkg::IDX_RELOAD: rbyte = r_reg.reload;
        i2m_pkg::IDX_STAT: rbyte = {r_reg.smp, r_reg.cke, 1'b0, r_reg.stop_seen, r_reg.start_seen, 2'h0, r_reg.bf};
        default: rhit = 1'b0;
      endcase
      if (!rhit)
      begin
        rbyte = 8'h00;
      end
      r_next.rvalid = 1'b1;
      r_next.rdata = rbyte;
      r_next.rresp = rhit ? i2m_pkg::RESP_OKAY : i2m_pkg::RESP_SLVERR;
    end

    // Bus sequencer
    case (r_reg.st)
      i2m_pkg::ST_IDLE:
      begin
        r_next.brg_run = 1'b0;
        if (r_reg.mode == i2m_pkg::MODE_MASTER)
        begin
          if (r_reg.con2[i2m_pkg::CON2_SEN])
          begin
            if (!r_reg.sda_s || !r_reg.scl_s)
            begin
              set_bcl = 1'b1;
              r_next.con2[i2m_pkg::CON2_SEN] = 1'b0;
            end
            else
            begin
              r_next.baud_rate_generator = r_reg.reload[i2m_pkg::RELOAD_W-1:0];
              r_next.brg_run = 1'b1;
              r_next.st = i2m_pkg::ST_START1;
            end
          end
          else if (r_reg.con2[i2m_pkg::CON2_REPEATED_START_ENABLE_BIT])
          begin
            r_next.scl_low = 1'b1;
            r_next.sda_low = 1'b0;
            r_next.st = i2m_pkg::ST_RS1;
          end
          else if (r_reg.con2[i2m_pkg::CON2_PEN])
          begin
            r_next.scl_low = 1'b1;
            r_next.sda_low = 1'b1;
            r_next.st = i2m_pkg::ST_STOP1;
          end
          else if (r_reg.con2[i2m_pkg::CON2_RECEIVE_ENABLE_BIT])
          begin
            r_next.op = i2m_pkg::OP_RX;
            r_next.bitcnt = i2m_pkg::BITS_RX;
            r_next.st = i2m_pkg::ST_BLOW;
          end
          else if (r_reg.con2[i2m_pkg::CON2_ACK_SEQUENCE_ENABLE])
          begin
            r_next.op = i2m_pkg::OP_ACK;
            r_next.bitcnt = i2m_pkg::BITS_ACK;
            r_next.st = i2m_pkg::ST_BLOW;
          end
          else if (r_reg.tx_req)
          begin
            r_next.tx_req = 1'b0;
            r_next.op = i2m_pkg::OP_TX;
            r_next.bitcnt = i2m_pkg::BITS_TX;
            r_next.st = i2m_pkg::ST_BLOW;
          end
        end
      end
      i2m_pkg::ST_START1:
      begin
        if (!r_reg.scl_s || (tmo && !r_reg.sda_s))
        begin
          set_bcl = 1'b1;
          r_next.con2[i2m_pkg::CON2_SEN] = 1'b0;
          r_next.st = i2m_pkg::ST_IDLE;
        end
        else if (tmo)
        begin
          r_next.sda_low = 1'b1;
          r_next.baud_rate_generator = r_reg.reload[i2m_pkg::RELOAD_W-1:0];
          r_next.st = i2m_pkg::ST_START2;
        end
      end
      i2m_pkg::ST_START2:
      begin
        if (tmo)
        begin
          // Generator halts with SDA still driven low
          r_next.con2[i2m_pkg::CON2_SEN] = 1'b0;
          r_next.brg_run = 1'b0;
          r_next.st = i2m_pkg::ST_IDLE;
          set_pif = 1'b1;
        end
      end
      i2m_pkg::ST_RS1:
      begin
        r_next.sda_low = 1'b0;
        if (!r_reg.brg_run && !r_reg.scl_s)
        begin
          r_next.baud_rate_generator = r_reg.reload[i2m_pkg::RELOAD_W-1:0];
          r_next.brg_run = 1'b1;
        end
        if (tmo)
        begin
          r_next.scl_low = 1'b0;
          r_next.brg_run = 1'b0;
          r_next.st = i2m_pkg::ST_RS2;
        end
      end
      i2m_pkg::ST_RS2:
      begin
        if ((!r_reg.brg_run && r_reg.scl_s && !r_reg.sda_s) || (tmo && !r_reg.scl_s))
        begin
          set_bcl = 1'b1;
          r_next.con2[i2m_pkg::CON2_REPEATED_START_ENABLE_BIT] = 1'b0;
          r_next.st = i2m_pkg::ST_IDLE;
        end
        else if (!r_reg.brg_run && r_reg.scl_s)
        begin
          r_next.baud_rate_generator = r_reg.reload[i2m_pkg::RELOAD_W-1:0];
          r_next.brg_run = 1'b1;
        end
        else if (tmo)
        begin
          r_next.sda_low = 1'b1;
          r_next.baud_rate_generator = r_reg.reload[i2m_pkg::RELOAD_W-1:0];
          r_next.st = i2m_pkg::ST_RS3;
        end
      end
      i2m_pkg::ST_RS3:
      begin
        if (!r_reg.scl_s)
        begin
          set_bcl = 1'b1;
          r_next.con2[i2m_pkg::CON2_REPEATED_START_ENABLE_BIT] = 1'b0;
          r_next.st = i2m_pkg::ST_IDLE;
        end
        else if (tmo)
        begin
          // Bus stays owned: SDA low, SCL high
          r_next.con2[i2m_pkg::CON2_REPEATED_START_ENABLE_BIT] = 1'b0;
          r_next.brg_run = 1'b0;
          r_next.st = i2m_pkg::ST_IDLE;
          set_pif = 1'b1;
        end
      end
      i2m_pkg::ST_BLOW:
      begin
        r_next.scl_low = 1'b1;
        if (!r_reg.brg_run && !r_reg.scl_s)
        begin
          case (r_reg.op)
            i2m_pkg::OP_TX: drv_bit = (r_reg.bitcnt == 4'h1) ? 1'b1 : r_reg.shreg[7];
            i2m_pkg::OP_ACK: drv_bit = r_reg.con2[i2m_pkg::CON2_ACK_DATA_BIT];
            default: drv_bit = 1'b1;
          endcase
          r_next.sda_low = !drv_bit;
          r_next.baud_rate_generator = r_reg.reload[i2m_pkg::RELOAD_W-1:0];
          r_next.brg_run = 1'b1;
        end
        if (tmo)
        begin
          r_next.scl_low = 1'b0;
          r_next.brg_run = 1'b0;
          r_next.st = i2m_pkg::ST_BHIGH;
        end
      end
      i2m_pkg::ST_BHIGH:
      begin
        // Another device stretching SCL delays the high count
        if (!r_reg.brg_run && r_reg.scl_s)
        begin
          r_next.baud_rate_generator = r_reg.reload[i2m_pkg::RELOAD_W-1:0];
          r_next.brg_run = 1'b1;
        end
        if (tmo)
        begin
          r_next.scl_low = 1'b1;
          r_next.brg_run = 1'b0;
          r_next.bitcnt = r_reg.bitcnt - 4'h1;
          r_next.st = (r_reg.bitcnt == 4'h1) ? i2m_pkg::ST_IDLE : i2m_pkg::ST_BLOW;
          if (!r_reg.sda_low && !r_reg.sda_s && (r_reg.op != i2m_pkg::OP_RX) &&
              ((r_reg.op == i2m_pkg::OP_ACK) || (r_reg.bitcnt != 4'h1)))
          begin
            // Released SDA read low: another master won
            set_bcl = 1'b1;
            r_next.sda_low = 1'b0;
            r_next.scl_low = 1'b0;
            r_next.con2[i2m_pkg::CON2_ACK_SEQUENCE_ENABLE] = 1'b0;
            r_next.st = i2m_pkg::ST_IDLE;
          end
          else
          begin
            r_next.shreg = shifted;
            if ((r_reg.op == i2m_pkg::OP_TX) && (r_reg.bitcnt == 4'h2))
            begin
              r_next.bf = 1'b0;
              r_next.sda_low = 1'b0;
            end
            if (r_reg.bitcnt == 4'h1)
            begin
              set_pif = 1'b1;
              r_next.sda_low = 1'b0;
              case (r_reg.op)
                i2m_pkg::OP_TX: r_next.con2[i2m_pkg::CON2_ACK_STATUS_BIT] = r_reg.sda_s;
                i2m_pkg::OP_ACK: r_next.con2[i2m_pkg::CON2_ACK_SEQUENCE_ENABLE] = 1'b0;
                default:
                begin
                  // Full buffer keeps its byte and flags overflow
                  if (r_reg.bf)
                  begin
                    r_next.ov = 1'b1;
                  end
                  else
                  begin
                    r_next.buf_data = shifted;
                  end
                  r_next.bf = 1'b1;
                  r_next.con2[i2m_pkg::CON2_RECEIVE_ENABLE_BIT] = 1'b0;
                end
              endcase
            end
          end
        end
      end
      i2m_pkg::ST_STOP1:
      begin
        if (!r_reg.brg_run && !r_reg.scl_s)
        begin
          r_next.baud_rate_generator = r_reg.reload[i2m_pkg::RELOAD_W-1:0];
          r_next.brg_run = 1'b1;
        end
        if (tmo)
        begin
          r_next.scl_low = 1'b0;
          r_next.brg_run = 1'b0;
          r_next.st = i2m_pkg::ST_STOP2;
        end
      end
      i2m_pkg::ST_STOP2:
      begin
        if (!r_reg.brg_run && r_reg.scl_s)
        begin
          r_next.baud_rate_generator = r_reg.reload[i2m_pkg::RELOAD_W-1:0];
          r_next.brg_run = 1'b1;
        end
        if (tmo)
        begin
          r_next.sda_low = 1'b0;
          r_next.baud_rate_generator = r_reg.reload[i2m_pkg::RELOAD_W-1:0];
          r_next.st = i2m_pkg::ST_STOP3;
        end
      end
      i2m_pkg::ST_STOP3:
      begin
        if (tmo)
        begin
          if (!r_reg.sda_s)
          begin
            set_bcl = 1'b1;
          end
          r_next.con2[i2m_pkg::CON2_PEN] = 1'b0;
          r_next.brg_run = 1'b0;
          r_next.st = i2m_pkg::ST_IDLE;
          set_pif = 1'b1;
        end
      end
      default: r_next.st = i2m_pkg::ST_IDLE;
    endcase

    // Disabled port: release the bus and forget bus state
    if (!r_reg.en)
    begin
      r_next.st = i2m_pkg::ST_IDLE;
      r_next.sda_low = 1'b0;
      r_next.scl_low = 1'b0;
      r_next.brg_run = 1'b0;
      r_next.tx_req = 1'b0;
      r_next.con2[4:0] = 5'h00;
      r_next.start_seen = 1'b0;
      r_next.stop_seen = 1'b0;
    end

    // Hardware sets beat a software clear in the same cycle
    if (set_pif)
    begin
      r_next.peripheral_interrupt_flags_1[i2m_pkg::PERIPHERAL_INTERRUPT_FLAGS_1_PIF] = 1'b1;
    end
    if (set_bcl)
    begin
      r_next.bcl = 1'b1;
    end
    if (set_write_collision_flag)
    begin
      r_next.write_collision_flag = 1'b1;
    end
    r_next.wake = cpu_sleep & r_next.peripheral_interrupt_flags_1[i2m_pkg::PERIPHERAL_INTERRUPT_FLAGS_1_PIF] & r_reg.peripheral_interrupt_enables_1[i2m_pkg::PERIPHERAL_INTERRUPT_FLAGS_1_PIF];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r_reg <= i2m_pkg::RST_STATE;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign s_axi_awready = !r_reg.aw_held;
  assign s_axi_wready = !r_reg.w_held;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_arready = !r_reg.rvalid;
  assign s_axi_rvalid = r_reg.rvalid;
  assign s_axi_rdata = {24'h000000, r_reg.rdata};
  assign s_axi_rresp = r_reg.rresp;
  // Open drain: only ever pull low
  assign sda_o = 1'b0;
  assign sda_oe = r_reg.sda_low;
  assign scl_o = 1'b0;
  assign scl_oe = r_reg.scl_low;
  assign cpu_wake = r_reg.wake;

endmodule : i2m_master

//--- logic/i2m_pkg.sv
package i2m_pkg;

  localparam int unsigned ADDR_W = 12;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PERIPHERAL_INTERRUPT_FLAGS_1 = 8'h0C;
  localparam logic [7:0] IDX_PERIPHERAL_INTERRUPT_FLAGS_2 = 8'h0D;
  localparam logic [7:0] IDX_BUF = 8'h13;
  localparam logic [7:0] IDX_CON = 8'h14;
  localparam logic [7:0] IDX_PERIPHERAL_INTERRUPT_ENABLES_1 = 8'h8C;
  localparam logic [7:0] IDX_PERIPHERAL_INTERRUPT_ENABLES_2 = 8'h8D;
  localparam logic [7:0] IDX_CON2 = 8'h91;
  localparam logic [7:0] IDX_RELOAD = 8'h93;
  localparam logic [7:0] IDX_STAT = 8'h94;

  // Field positions
  localparam int unsigned PERIPHERAL_INTERRUPT_FLAGS_1_PIF = 3;
  localparam int unsigned PERIPHERAL_INTERRUPT_FLAGS_2_BCL = 3;
  localparam int unsigned CON_WRITE_COLLISION_FLAG = 7;
  localparam int unsigned CON_OV = 6;
  localparam int unsigned CON_EN = 5;
  localparam int unsigned CON_CKP = 4;
  localparam int unsigned CON2_GENERAL_CALL_ENABLE = 7;
  localparam int unsigned CON2_ACK_STATUS_BIT = 6;
  localparam int unsigned CON2_ACK_DATA_BIT = 5;
  localparam int unsigned CON2_ACK_SEQUENCE_ENABLE = 4;
  localparam int unsigned CON2_RECEIVE_ENABLE_BIT = 3;
  localparam int unsigned CON2_PEN = 2;
  localparam int unsigned CON2_REPEATED_START_ENABLE_BIT = 1;
  localparam int unsigned CON2_SEN = 0;
  localparam int unsigned STAT_SMP = 7;
  localparam int unsigned STAT_CKE = 6;
  localparam int unsigned STAT_P = 4;
  localparam int unsigned STAT_S = 3;
  localparam int unsigned STAT_BF = 0;

  localparam logic [3:0] MODE_MASTER = 4'h8;
  localparam int unsigned RELOAD_W = 7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] BITS_TX = 4'h9;
  localparam logic [3:0] BITS_RX = 4'h8;
  localparam logic [3:0] BITS_ACK = 4'h1;

  typedef enum logic [3:0] {
    ST_IDLE, ST_START1, ST_START2, ST_RS1, ST_RS2, ST_RS3,
    ST_BLOW, ST_BHIGH, ST_STOP1, ST_STOP2, ST_STOP3
  } i2m_state_t;

  typedef enum logic [1:0] {OP_TX, OP_RX, OP_ACK} i2m_op_t;

  typedef struct packed {
    logic sda_m, sda_s, sda_d, scl_m, scl_s, scl_d;
    logic [1:0] phase;
    logic [RELOAD_W-1:0] baud_rate_generator;
    logic brg_run;
    i2m_state_t st;
    i2m_op_t op;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic sda_low, scl_low;
    logic tx_req;
    logic [7:0] peripheral_interrupt_flags_1, peripheral_interrupt_enables_1, buf_data, con2, reload;
    logic bcl, bcle, write_collision_flag, ov, en, clock_release_bit, smp, cke, stop_seen, start_seen, bf, wake;
    logic [3:0] mode;
    logic aw_held, w_held, bvalid, rvalid;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane0;
    logic [1:0] bresp, rresp;
    logic [7:0] rdata;
  } i2m_regs_t;

  localparam i2m_regs_t RST_STATE = '0;

endpackage : i2m_pkg

//--- verification/i2m_slave_model.sv
`timescale 1ns/1ps
module i2m_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic nak,
  input wire logic stretch,
  output logic sda_pull,
  output logic scl_pull,
  output logic [7:0] byte_q
);
  logic [7:0] sreg;
  int cnt;
  initial
  begin
    sda_pull = 1'b0;
    scl_pull = 1'b0;
    byte_q = 8'h00;
    cnt = 0;
  end
  always @(negedge sda) if (scl) cnt = 0;
  always @(posedge scl)
  begin
    sreg = {sreg[6:0], sda};
    cnt++;
  end
  // Ack held through the ninth clock only; stretch tests the master waiting on SCL
  always @(negedge scl)
  begin
    if (cnt == 8) byte_q = sreg;
    sda_pull = (cnt == 8) && !nak;
    if (cnt == 9) cnt = 0;
    if (stretch)
    begin
      scl_pull = 1'b1;
      #400 scl_pull = 1'b0;
    end
  end
endmodule : i2m_slave_model

//--- verification/i2m_master_asserts.sv
`timescale 1ns/1ps
module i2m_master_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic cpu_sleep,
  input wire logic cpu_wake
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Reset itself is the cause here, so this one cannot be disabled by it
  chk_reset_lines: assert property (disable iff (1'b0) !aresetn |=> !sda_oe && !scl_oe)
    else $error("lines driven after reset");
  chk_wake_cause: assert property (cpu_wake |-> $past(cpu_sleep))
    else $error("wake without sleep");
  chk_wake_drop: assert property (!cpu_sleep |=> !cpu_wake)
    else $error("wake while awake");
  chk_open_drain: assert property (sda_o == 1'b0 && scl_o == 1'b0)
    else $error("line driven high");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:4] s_axi_bvalid) else $error("no write response");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read response");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  cov_start: cover property ($rose(sda_oe) && sda_i == 1'b0 && !scl_oe);
  cov_wake: cover property ($rose(cpu_wake));
  cov_slverr: cover property (s_axi_rvalid && s_axi_rresp == i2m_pkg::RESP_SLVERR);
endmodule : i2m_master_asserts
bind i2m_master i2m_master_asserts u_chk (.*);

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cpu_sleep = 1'b0, nak = 1'b0, stretch = 1'b0, hold = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, rdv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sda_o, sda_oe, scl_o, scl_oe;
  logic cpu_wake, sda_pull, scl_pull;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata;
  logic [7:0] byte_q;
  int errors = 0, n_checks = 0;
  wire sda_i = !(sda_oe || sda_pull || hold);
  wire scl_i = !(scl_oe || scl_pull);
  always #20 aclk = ~aclk;
  i2m_master u_dut (.*);
  i2m_slave_model u_slave (.scl(scl_i), .sda(sda_i), .nak(nak), .stretch(stretch), .sda_pull(sda_pull),
    .scl_pull(scl_pull), .byte_q(byte_q));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkr(input logic [1:0] exp);
    chk({30'h0, rsp}, {30'h0, exp});
  endtask : chkr
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid === 1'b1;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end while (!tb);
  endtask : wr
  task automatic rd(input logic [7:0] idx);
    logic ta, tb;
    @(posedge aclk);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tb = s_axi_rvalid === 1'b1;
      rdv = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tb) s_axi_rready <= 1'b0;
    end while (!tb);
  endtask : rd
  // Polls the flag but leaves it set; software alone clears it
  task automatic wflag();
    int i;
    rdv = 32'h0;
    for (i = 0; i < 300 && rdv[3] !== 1'b1; i++) rd(i2m_pkg::IDX_PERIPHERAL_INTERRUPT_FLAGS_1);
    chk(rdv & 32'h08, 32'h08);
  endtask : wflag
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  initial
  begin
    #400000;
    errors++;
    conclude();
  end
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(i2m_pkg::IDX_STAT); chk(rdv, 32'h0);
    rd(i2m_pkg::IDX_CON2); chk(rdv, 32'h0);
    rd(8'h00); chkr(i2m_pkg::RESP_SLVERR);
    wr(i2m_pkg::IDX_RELOAD, 8'h02);
    wr(i2m_pkg::IDX_PERIPHERAL_INTERRUPT_ENABLES_1, 8'h08);
    wr(i2m_pkg::IDX_CON, 8'h28);
    rd(i2m_pkg::IDX_STAT); chk(rdv & 32'h18, 32'h0);
    wr(i2m_pkg::IDX_CON2, 8'h01);
    wr(i2m_pkg::IDX_BUF, 8'h77);
    rd(i2m_pkg::IDX_CON); chk(rdv & 32'h80, 32'h80);
    wflag();
    rd(i2m_pkg::IDX_CON2); chk(rdv & 32'h01, 32'h0);
    chk({sda_oe, scl_oe}, 2'b10);
    wr(i2m_pkg::IDX_PERIPHERAL_INTERRUPT_FLAGS_1, 8'h00);
    wr(i2m_pkg::IDX_CON, 8'h28);
    wr(i2m_pkg::IDX_BUF, 8'hA4);
    wflag();
    chk(byte_q, 8'hA4);
    rd(i2m_pkg::IDX_CON2); chk(rdv & 32'h40, 32'h0);
    wr(i2m_pkg::IDX_PERIPHERAL_INTERRUPT_FLAGS_1, 8'h00);
    // Slave leaves SDA released while master receives, so the byte reads all ones
    wr(i2m_pkg::IDX_CON2, 8'h08);
    wflag();
    rd(i2m_pkg::IDX_BUF); chk(rdv, 32'hFF);
    wr(i2m_pkg::IDX_PERIPHERAL_INTERRUPT_FLAGS_1, 8'h00);
    wr(i2m_pkg::IDX_CON2, 8'h10);
    wflag();
    rd(i2m_pkg::IDX_CON2); chk(rdv & 32'h10, 32'h0);
    wr(i2m_pkg::IDX_PERIPHERAL_INTERRUPT_FLAGS_1, 8'h00);
    nak <= 1'b1;
    stretch <= 1'b1;
    wr(i2m_pkg::IDX_BUF, 8'h3C);
    wflag();
    chk(byte_q, 8'h3C);
    rd(i2m_pkg::IDX_CON2); chk(rdv & 32'h40, 32'h40);
    nak <= 1'b0;
    stretch <= 1'b0;
    wr(i2m_pkg::IDX_PERIPHERAL_INTERRUPT_FLAGS_1, 8'h00);
    wr(i2m_pkg::IDX_CON2, 8'h02);
    wflag();
    chk({sda_oe, scl_oe}, 2'b10);
    wr(i2m_pkg::IDX_PERIPHERAL_INTERRUPT_FLAGS_1, 8'h00);
    cpu_sleep <= 1'b1;
    wr(i2m_pkg::IDX_CON2, 8'h04);
    wflag();
    chk(cpu_wake, 1'b1);
    chk({sda_oe, scl_oe}, 2'b00);
    rd(i2m_pkg::IDX_STAT); chk(rdv & 32'h10, 32'h10);
    // Flag above may come from bus stop detection; let the stop sequence finish
    repeat (20) @(posedge aclk);
    rd(i2m_pkg::IDX_CON2); chk(rdv & 32'h04, 32'h0);
    cpu_sleep <= 1'b0;
    wr(i2m_pkg::IDX_PERIPHERAL_INTERRUPT_FLAGS_1, 8'h00);
    hold <= 1'b1;
    wr(i2m_pkg::IDX_CON2, 8'h01);
    repeat (20) @(posedge aclk);
    rd(i2m_pkg::IDX_PERIPHERAL_INTERRUPT_FLAGS_2); chk(rdv & 32'h08, 32'h08);
    chk(sda_oe, 1'b0);
    hold <= 1'b0;
    wr(i2m_pkg::IDX_CON, 8'h08);
    rd(i2m_pkg::IDX_STAT); chk(rdv & 32'h18, 32'h0);
    conclude();
  end
endmodule : testbench
